// ---- hdl/bst_tap.sv ----
// boundary-scan tap controller with instruction, id, bypass and scan chain
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
// ==========================================================
module bst_tap #(
    parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
    parameter logic [15:0] ID_PART = 16'h1234, // arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h055, // arbitrary value
    parameter logic [bst_pkg::BST_CHAIN_LEN-1:0] ENABLE_MASK = '0 // 1 marks an enable cell
) (
    input wire logic clock, // 125 MHz system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [3:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic tck, // test clock pin
    input wire logic tms, // test mode select pin
    input wire logic tdi, // test data in pin
    input wire logic trst_n, // test reset pin, low
    output logic tdo_o, // test data out value
    output logic tdo_oe, // test data out enable
    input wire logic cpu_reset, // processor reset pin, high
    input wire logic [bst_pkg::BST_CHAIN_LEN-1:0] pin_all, // state of every pin
    input wire logic [bst_pkg::BST_CHAIN_LEN-1:0] pin_inputs, // pins, bidis as inputs
    output logic [bst_pkg::BST_CHAIN_LEN-1:0] scan_value, // chain output register
    output logic [bst_pkg::BST_CHAIN_LEN-1:0] scan_drive, // per pin: drive from chain
    output logic pins_float, // float all outputs
    output logic test_mode // core held in test operation
);
    import bst_pkg::*;

    bst_state_t st;
    bst_state_t next_st;
    bst_av_req_t req;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic trst_s;
    logic cpu_rst_s;
    logic rise;
    logic fall;
    logic tap_rst;
    logic sel_chain;
    logic sel_id;
    logic [31:0] id_word;

    // ==========================================================
    // decode
    assign req = '{avs_address, avs_read, avs_write, avs_writedata};
    assign {cpu_rst_s, trst_s, tdi_s, tms_s, tck_s} = st.sync_s;
    assign rise = tck_s & ~st.tck_d;
    assign fall = ~tck_s & st.tck_d;
    assign tap_rst = cpu_rst_s | ~trst_s | st.ctrl[BST_CTRL_SOFT_RST];
    assign sel_chain = (st.ir == BST_IR_EXTEST) || (st.ir == BST_IR_SAMPLE);
    assign sel_id = (st.ir == BST_IR_IDCODE);
    assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.sync_m = {cpu_reset, trst_n, tdi, tms, tck};
        next_st.sync_s = st.sync_m;
        next_st.tck_d = tck_s;
        if (rise) begin
            unique case (st.tap)
                BST_TLR: next_st.tap = tms_s ? BST_TLR : BST_RTI;
                BST_RTI: next_st.tap = tms_s ? BST_SEL_DR : BST_RTI;
                BST_SEL_DR: next_st.tap = tms_s ? BST_SEL_IR : BST_CAP_DR;
                BST_CAP_DR: next_st.tap = tms_s ? BST_EX1_DR : BST_SH_DR;
                BST_SH_DR: next_st.tap = tms_s ? BST_EX1_DR : BST_SH_DR;
                BST_EX1_DR: next_st.tap = tms_s ? BST_UPD_DR : BST_PAU_DR;
                BST_PAU_DR: next_st.tap = tms_s ? BST_EX2_DR : BST_PAU_DR;
                BST_EX2_DR: next_st.tap = tms_s ? BST_UPD_DR : BST_SH_DR;
                BST_UPD_DR: next_st.tap = tms_s ? BST_SEL_DR : BST_RTI;
                BST_SEL_IR: next_st.tap = tms_s ? BST_TLR : BST_CAP_IR;
                BST_CAP_IR: next_st.tap = tms_s ? BST_EX1_IR : BST_SH_IR;
                BST_SH_IR: next_st.tap = tms_s ? BST_EX1_IR : BST_SH_IR;
                BST_EX1_IR: next_st.tap = tms_s ? BST_UPD_IR : BST_PAU_IR;
                BST_PAU_IR: next_st.tap = tms_s ? BST_EX2_IR : BST_PAU_IR;
                BST_EX2_IR: next_st.tap = tms_s ? BST_UPD_IR : BST_SH_IR;
                BST_UPD_IR: next_st.tap = tms_s ? BST_SEL_DR : BST_RTI;
            endcase
            unique case (st.tap)
                BST_CAP_IR: next_st.ir_sh = BST_IR_CAPTURE;
                BST_SH_IR: next_st.ir_sh = {tdi_s, st.ir_sh[4:1]};
                BST_CAP_DR: begin
                    next_st.byp = 1'b0;
                    next_st.id_sh = id_word;
                    if (st.ir == BST_IR_EXTEST) begin
                        next_st.chain_sh = pin_inputs;
                    end else if (st.ir == BST_IR_SAMPLE) begin
                        next_st.chain_sh = pin_all;
                    end
                end
                BST_SH_DR: begin
                    if (sel_chain) begin
                        next_st.chain_sh = {tdi_s, st.chain_sh[BST_CHAIN_LEN-1:1]};
                    end else if (sel_id) begin
                        next_st.id_sh = {tdi_s, st.id_sh[31:1]};
                    end else begin
                        next_st.byp = tdi_s;
                    end
                end
                default: ;
            endcase
        end
        // cpu reset clears first, so an extest update in the same cycle still sets
        if (cpu_rst_s) begin
            next_st.test_mode = 1'b0;
        end
        if (fall) begin
            next_st.tdo_oe = (st.tap == BST_SH_DR) || (st.tap == BST_SH_IR);
            if (st.tap == BST_SH_IR) begin
                next_st.tdo = st.ir_sh[0];
            end else if (sel_chain) begin
                next_st.tdo = st.chain_sh[0];
            end else if (sel_id) begin
                next_st.tdo = st.id_sh[0];
            end else begin
                next_st.tdo = st.byp;
            end
            if (st.tap == BST_UPD_IR) begin
                next_st.ir = st.ir_sh;
                if (st.ir_sh == BST_IR_EXTEST) begin
                    next_st.test_mode = 1'b1;
                end
            end
            if (st.tap == BST_UPD_DR && sel_chain) begin
                next_st.chain_out = st.chain_sh;
            end
        end
        if (tap_rst) begin
            next_st.tap = BST_TLR;
        end
        if (next_st.tap == BST_TLR) begin
            next_st.ir = BST_IR_IDCODE;
        end
        // register bus: one wait cycle, then answer
        next_st.ack = (req.read | req.write) & ~st.ack;
        next_st.rdata = '0;
        if (req.read & ~st.ack) begin
            unique case (req.address)
                BST_ADDR_CTRL: next_st.rdata = {30'h0, st.ctrl};
                BST_ADDR_STATUS: begin
                    next_st.rdata[BST_ST_STATE_LSB +: 4] = st.tap;
                    next_st.rdata[BST_ST_IR_LSB +: 5] = st.ir;
                    next_st.rdata[BST_ST_TEST_MODE] = st.test_mode;
                end
                BST_ADDR_IDCODE: next_st.rdata = id_word;
                default: next_st.rdata = '0;
            endcase
        end
        if (req.write & st.ack && req.address == BST_ADDR_CTRL) begin
            next_st.ctrl = req.writedata[1:0];
        end
        if (sys_rst) begin
            next_st = '0;
            next_st.sync_m = 5'h0c;
            next_st.sync_s = 5'h0c;
            next_st.tap = BST_TLR;
            next_st.ir = BST_IR_IDCODE;
            next_st.ctrl = BST_CTRL_RESET;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    // ==========================================================
    // pin drive: enable cell i controls pin cell i-1
    assign scan_value = st.chain_out;
    genvar gi;
    generate
        for (gi = 0; gi < BST_CHAIN_LEN; gi++) begin : g_drive
            // reserved bit 0 and the top cell have no pin below an enable
            if (gi == 0 || gi == BST_CHAIN_LEN - 1) begin : g_end
                assign scan_drive[gi] = 1'b0;
            end else if (ENABLE_MASK[gi + 1] && !ENABLE_MASK[gi]) begin : g_en
                assign scan_drive[gi] = (st.ir == BST_IR_EXTEST) & st.chain_out[gi + 1];
            end else begin : g_no
                assign scan_drive[gi] = 1'b0;
            end
        end
    endgenerate
    assign pins_float = (st.ir == BST_IR_HIGHZ);
    assign test_mode = st.test_mode;
    assign tdo_o = st.tdo;
    assign tdo_oe = st.tdo_oe;
    assign avs_readdata = st.rdata;
    assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;

endmodule // bst_tap

// ---- shared/bst_pkg.sv ----
// package: constants, types and state record of the boundary-scan tap unit
package bst_pkg;

    // ==========================================================
    // instruction codes
    localparam logic [4:0] BST_IR_EXTEST = 5'h00;
    localparam logic [4:0] BST_IR_SAMPLE = 5'h01;
    localparam logic [4:0] BST_IR_IDCODE = 5'h02;
    localparam logic [4:0] BST_IR_HIGHZ = 5'h03;
    localparam logic [4:0] BST_IR_BYPASS = 5'h1f;
    localparam logic [4:0] BST_IR_CAPTURE = 5'h01;

    // ==========================================================
    // chain and id layout
    localparam int BST_CHAIN_LEN = 281;
    localparam int BST_ID_VER_LSB = 28;
    localparam int BST_ID_PART_LSB = 12;
    localparam int BST_ID_MAKER_LSB = 1;

    // ==========================================================
    // register map (byte addresses) and fields
    localparam logic [3:0] BST_ADDR_CTRL = 4'h0;
    localparam logic [3:0] BST_ADDR_STATUS = 4'h4;
    localparam logic [3:0] BST_ADDR_IDCODE = 4'h8;
    localparam int BST_CTRL_SOFT_RST = 0;
    localparam logic [1:0] BST_CTRL_RESET = 2'h0;
    localparam int BST_ST_STATE_LSB = 0;
    localparam int BST_ST_IR_LSB = 4;
    localparam int BST_ST_TEST_MODE = 9;

    typedef enum logic [3:0] {
        BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR, BST_PAU_DR,
        BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR,
        BST_PAU_IR, BST_EX2_IR, BST_UPD_IR
    } bst_tap_state_t;

    // avalon slave request bundle
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } bst_av_req_t;

    // whole module state
    typedef struct packed {
        logic [4:0] sync_m;
        logic [4:0] sync_s;
        logic tck_d;
        bst_tap_state_t tap;
        logic [4:0] ir_sh;
        logic [4:0] ir;
        logic [BST_CHAIN_LEN-1:0] chain_sh;
        logic [BST_CHAIN_LEN-1:0] chain_out;
        logic [31:0] id_sh;
        logic byp;
        logic tdo;
        logic tdo_oe;
        logic test_mode;
        logic [1:0] ctrl;
        logic ack;
        logic [31:0] rdata;
    } bst_state_t;

endpackage

// ---- sim/bst_tap_assertions.sv ----
// checker: port assertions of the tap unit
`timescale 1ns/1ps
// ==========
// checker
module bst_tap_chk (
    input wire logic clock, // clock
    input wire logic sys_rst, // reset
    input wire logic [3:0] avs_address, // address
    input wire logic avs_read, // read
    input wire logic avs_write, // write
    input wire logic [31:0] avs_readdata, // data
    input wire logic avs_waitrequest, // stall
    input wire logic trst_n, // tap reset
    input wire logic cpu_reset, // cpu reset
    input wire logic tdo_oe, // tdo enable
    input wire logic [bst_pkg::BST_CHAIN_LEN-1:0] scan_value, // chain out
    input wire logic [bst_pkg::BST_CHAIN_LEN-1:0] scan_drive, // drives
    input wire logic pins_float, // float
    input wire logic test_mode // test mode
);
    import bst_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered");
    AST_NULL_READ: assert property (avs_read && !avs_waitrequest && avs_address == 4'hc
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    AST_TM_HOLD: assert property ((!cpu_reset)[*4] ##0 test_mode |=> test_mode)
        else $error("test mode lost");
    AST_TM_CLEAR: assert property (cpu_reset[*5] |-> !test_mode)
        else $error("test mode kept");
    AST_TRST_IR: assert property ((!trst_n)[*5] |-> !pins_float && scan_drive == '0)
        else $error("tap reset ignored");
    AST_DRIVE_CELL: assert property ((scan_drive & ~(scan_value >> 1)) == '0)
        else $error("pin driven while enable zero");
    AST_HIGHZ: assert property (pins_float |-> scan_drive == '0)
        else $error("pin driven while floated");
    AST_SHIFT_HOLD: assert property (tdo_oe && $past(tdo_oe) |-> $stable(scan_value))
        else $error("output register moved in shift");
    cover property ($rose(test_mode));
    cover property (pins_float);
    cover property (scan_drive != '0);
endmodule // bst_tap_chk
bind bst_tap bst_tap_chk bst_tap_chk_i (.clock(clock), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trst_n(trst_n),
    .cpu_reset(cpu_reset), .tdo_oe(tdo_oe), .scan_value(scan_value),
    .scan_drive(scan_drive), .pins_float(pins_float), .test_mode(test_mode));

// ---- sim/bst_tester.sv ----
// tester model driving the test pins
`timescale 1ns/1ps
// ==========
// tester
module bst_tester (
    input wire logic clock, // clock
    input wire logic tdo_o, // tdo
    output logic tck = 1'b0, // starts low, rests high between steps
    output logic tms = 1'b1, // mode
    output logic tdi = 1'b1 // idles high
);
    import bst_pkg::*;
    logic q;
    // one tck period; tdo taken at the rise
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clock);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clock);
        o = tdo_o;
        tck <= 1'b1;
        repeat (3) @(posedge clock);
    endtask
    task automatic tlr();
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
    // capture, shift n bits lsb first, pause after bit p, update
    task automatic scan(input logic ir, input int n, input int p,
        input logic [BST_CHAIN_LEN-1:0] din, output logic [BST_CHAIN_LEN-1:0] dout);
        dout = '0;
        step(1'b0, 1'b1, q);
        step(1'b1, 1'b1, q);
        if (ir) step(1'b1, 1'b1, q);
        repeat (2) step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1 || i == p, din[i], dout[i]);
            if (i == p) begin
                step(1'b0, 1'b1, q);
                step(1'b1, 1'b1, q);
                step(1'b0, 1'b1, q);
            end
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask
endmodule // bst_tester

// ---- sim/tb_top.sv ----
// testbench of the boundary-scan tap unit
`timescale 1ns/1ps
// ==========
// bench
module tb_top;
    import bst_pkg::*;
    localparam logic [31:0] ID = {4'h3, 16'h2c4e, 11'h2a1, 1'b1}; // arbitrary id
    localparam logic [280:0] MASK = {1'b1, {139{2'b01}}, 2'b00};
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic trst_n = 1'b1;
    logic cpu_reset = 1'b0;
    bst_av_req_t av = '0;
    logic [280:0] pin_all = '0;
    logic [280:0] pin_in = '0;
    logic [280:0] din, dout, sv, sd;
    logic [31:0] rd, q32;
    logic tck, tms, tdi, tdo, wait_r, flt, tm;
    int err_total = 0;
    int compares = 0;
    int seed = 84;
    int exp_ir = 2;
    int codes[$] = '{3, 4, 17, 30};
    initial forever #4 clock = ~clock;
    bst_tap #(.ID_VERSION(ID[31:28]), .ID_PART(ID[27:12]), .ID_MAKER(ID[11:1]),
        .ENABLE_MASK(MASK)) bst_tap_i (.clock(clock), .sys_rst(sys_rst),
        .avs_address(av.address), .avs_read(av.read), .avs_write(av.write),
        .avs_writedata(av.writedata), .avs_readdata(rd), .avs_waitrequest(wait_r),
        .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_o(tdo), .tdo_oe(),
        .cpu_reset(cpu_reset), .pin_all(pin_all), .pin_inputs(pin_in), .scan_value(sv),
        .scan_drive(sd), .pins_float(flt), .test_mode(tm));
    bst_tester bst_tester_i (.clock(clock), .tdo_o(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    task automatic complete_run();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [280:0] seen, input logic [280:0] want);
        compares++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    function automatic logic [280:0] rnd();
        logic [280:0] r = '0;
        for (int i = 0; i < 9; i++) r = {r[248:0], 32'($random(seed))};
        return r;
    endfunction
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        av <= '{a, !wr, wr, d};
        do begin
            @(posedge clock);
        end while (wait_r !== 1'b0);
        q32 = rd;
        av <= '0;
    endtask
    task automatic status(input int st);
        bus(1'b0, BST_ADDR_STATUS, 32'h0);
        chk(q32[8:0], {exp_ir[4:0], st[3:0]});
    endtask
    task automatic ir(input int c);
        exp_ir = c;
        din = 281'(c);
        bst_tester_i.scan(1'b1, 5, -1, din, dout);
        chk(dout[4:0], 5'h01);
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        bus(1'b0, BST_ADDR_CTRL, 32'h0);
        chk(q32, 32'h0);
        bus(1'b0, 4'hc, 32'h0);
        chk(q32, 32'h0);
        status(0);
        bus(1'b0, BST_ADDR_IDCODE, 32'h0);
        chk(q32, ID);
        bst_tester_i.scan(1'b0, 32, -1, '1, dout);
        chk(dout[31:0], ID);
        foreach (codes[k]) begin
            ir(codes[k]);
            status(1);
            chk(flt, exp_ir == 3);
            din = rnd();
            bst_tester_i.scan(1'b0, 9, -1, din, dout);
            chk(dout[8:0], {din[7:0], 1'b0});
        end
        ir(31);
        status(1);
        ir(1);
        pin_all <= rnd();
        din = rnd();
        bst_tester_i.scan(1'b0, 281, 100, din, dout);
        chk(dout[280:1], pin_all[280:1]);
        chk(sv, din);
        ir(0);
        chk(tm, 1'b1);
        pin_in <= rnd();
        din = rnd();
        bst_tester_i.scan(1'b0, 281, -1, din, dout);
        chk(dout[280:1], pin_in[280:1]);
        chk(sd, (din & MASK) >> 1);
        ir(31);
        chk(tm, 1'b1);
        cpu_reset <= 1'b1;
        repeat (6) @(posedge clock);
        cpu_reset <= 1'b0;
        repeat (4) @(posedge clock);
        exp_ir = 2;
        chk(tm, 1'b0);
        status(0);
        for (int k = 0; k < 3; k++) begin
            ir(3);
            if (k == 0) trst_n <= 1'b0;
            if (k == 1) bst_tester_i.tlr();
            if (k == 2) bus(1'b1, BST_ADDR_CTRL, 32'h1);
            repeat (6) @(posedge clock);
            trst_n <= 1'b1;
            if (k == 2) bus(1'b1, BST_ADDR_CTRL, 32'h0);
            repeat (4) @(posedge clock);
            exp_ir = 2;
            status(int'(k == 1));
        end
        complete_run();
    end
endmodule // tb_top
